// file: dpbrf_fab.sv
// fabric model driving the write and push side (port b) of the memory
`timescale 1ns/100ps
module dpbrf_fab
	import dpbrf_pkg::*;
(
	input wire logic clk_i,
	output logic b_en_o,
	output logic b_we_o,
	output logic [14:0] b_addr_o,
	output logic [71:0] b_din_o
);
	initial
	begin
		b_en_o = 1'b0;
		b_we_o = 1'b0;
		b_addr_o = 15'h0;
		b_din_o = 72'h0;
	end
	// ========
	// one write or push, after gap idle cycles of stall
	task automatic wr(logic [14:0] a, logic [71:0] d, int gap);
		repeat (gap) @(posedge clk_i);
		@(posedge clk_i);
		b_en_o <= 1'b1;
		b_we_o <= 1'b1;
		b_addr_o <= a;
		b_din_o <= d;
		@(posedge clk_i);
		b_en_o <= 1'b0;
		b_we_o <= 1'b0;
		// released lines show garbage so a stale word never passes as data
		b_addr_o <= ~a;
		b_din_o <= ~d;
	endtask
endmodule

// file: dpbrf_pkg.sv
// package: constants and types of the dual-port block memory with fifo
package dpbrf_pkg;
// ==========================================================================
// geometry
localparam int DPBRF_ROWS = 512;
localparam logic [2:0] DPBRF_W_X18 = 3'h4;
localparam logic [2:0] DPBRF_W_X36 = 3'h5;
localparam logic [2:0] DPBRF_W_X72 = 3'h6;
localparam logic [15:0] DPBRF_FULL_UNITS = 16'h8000;
localparam logic [15:0] DPBRF_HALF_UNITS = 16'h4000;
// ==========================================================================
// register map, byte addresses
localparam logic [4:0] DPBRF_REG_CFG = 5'h00;
localparam logic [4:0] DPBRF_REG_AF_THR = 5'h04;
localparam logic [4:0] DPBRF_REG_AE_THR = 5'h08;
localparam logic [4:0] DPBRF_REG_STATUS = 5'h0C;
localparam logic [4:0] DPBRF_REG_FIFO_CLR = 5'h10;
// ==========================================================================
// configuration fields
localparam int DPBRF_CFG_W = 17;
localparam int DPBRF_CFG_FIFO = 0;
localparam int DPBRF_CFG_SPLIT = 1;
localparam int DPBRF_CFG_SRW = 2;
localparam int DPBRF_CFG_ECC = 3;
localparam int DPBRF_CFG_A_W = 4;
localparam int DPBRF_CFG_B_W = 7;
localparam int DPBRF_CFG_A_OREG = 10;
localparam int DPBRF_CFG_B_OREG = 11;
localparam int DPBRF_CFG_A_WM = 12;
localparam int DPBRF_CFG_B_WM = 14;
localparam int DPBRF_CFG_CASC = 16;
localparam logic [16:0] DPBRF_CFG_RST = 17'h002D0;
localparam logic [15:0] DPBRF_THR_RST = 16'h0040;
// ==========================================================================
// types
typedef enum logic [1:0] {
	DPBRF_WM_WRFIRST = 2'h0,
	DPBRF_WM_RDFIRST = 2'h1,
	DPBRF_WM_HOLD = 2'h2
} dpbrf_wmode_t;
endpackage

// file: dpbrf_top.sv
// dual-port block memory with aspect ratios, split halves, ecc and fifo
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/100ps
// Overview of operation
// R1 - each port picks x1 up to x72 organisation, parity widths 9/18/36/72
// R2 - both ports choose their organisation independently, in ram and fifo
// R3 - memory splits into two independent halves, x1 to x36 each
// R4 - wide widths above 18 half or 36 full only in split read/write mode
// R5 - split read/write mode: port a only reads, port b only writes
// R6 - split read/write mode: one side fixed at the widest width
// R7 - true dual-port full memory lets both ports choose a width
// R8 - ecc on 64-bit words stores eight hamming check bits per write
// R9 - protected reads correct single errors and flag double errors
// R10 - encoder and decoder also usable alone for external memories
// R11 - memory works as a full-size or half-size fifo
// R12 - fifo advances its own pointers; one common clock here
// R13 - fifo gives full, empty, almost-full and almost-empty flags
// R14 - almost flags assert at user-programmed occupancy counts
// R15 - fifo width and depth programmable, read width may differ
// R16 - cascade path chains fifos into one deeper fifo
// R17 - two independent ports share only the stored contents
// R18 - all port inputs are taken on the clock edge
// R19 - optional output register adds one cycle of read latency
// R20 - during a write dout shows old data, new data, or holds
// R21 - push when full or pop when empty changes nothing
// R22 - protected reads give single and double error outputs with data
module dpbrf_top
	import dpbrf_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [4:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	input wire logic a_en_i,
	input wire logic a_we_i,
	input wire logic [14:0] a_addr_i,
	input wire logic a_half_i,
	input wire logic [71:0] a_din_i,
	output logic [71:0] a_dout_o,
	output logic a_valid_o,
	output logic a_sbe_o,
	output logic a_dbe_o,
	input wire logic b_en_i,
	input wire logic b_we_i,
	input wire logic [14:0] b_addr_i,
	input wire logic b_half_i,
	input wire logic [71:0] b_din_i,
	output logic [71:0] b_dout_o,
	output logic b_valid_o,
	output logic fifo_full_o,
	output logic fifo_empty_o,
	output logic fifo_afull_o,
	output logic fifo_aempty_o,
	input wire logic [71:0] casc_din_i,
	input wire logic casc_push_i,
	output logic casc_ready_o,
	input wire logic casc_ready_i,
	output logic casc_valid_o,
	input wire logic [63:0] ecc_enc_din_i,
	output logic [7:0] ecc_enc_chk_o,
	input wire logic [71:0] ecc_dec_din_i,
	output logic [63:0] ecc_dec_dout_o,
	output logic ecc_dec_sbe_o,
	output logic ecc_dec_dbe_o
);
// ==========================================================================
// bit mapping: a row is 8 lanes of 9 bits, bit 8 of a lane is parity
function automatic int jmap(input logic [2:0] c, input logic [5:0] o,
	input int p);
	if (c <= 3'h2)
		return (p / 9) * 8 + p % 9 - int'(o);
	return p - (int'(o) / 8) * 9;
endfunction

function automatic logic [71:0] lmask(input logic [2:0] c,
	input logic [5:0] o);
	logic [71:0] m;
	int w;
	w = (c <= 3'h2) ? (1 << c) : (9 << (int'(c) - 3));
	for (int p = 0; p < 72; p++)
		m[p] = (c > 3'h2 || p % 9 != 8) && jmap(c, o, p) >= 0 &&
			jmap(c, o, p) < w;
	return m;
endfunction

function automatic logic [71:0] spread(input logic [2:0] c,
	input logic [5:0] o, input logic [71:0] x);
	logic [71:0] m;
	logic [71:0] s;
	m = lmask(c, o);
	s = '0;
	for (int p = 0; p < 72; p++)
		if (m[p])
			s[p] = x[7'(jmap(c, o, p))];
	return s;
endfunction

function automatic logic [71:0] extract(input logic [2:0] c,
	input logic [5:0] o, input logic [71:0] r);
	logic [71:0] m;
	logic [71:0] e;
	m = lmask(c, o);
	e = '0;
	for (int p = 0; p < 72; p++)
		if (m[p])
			e[7'(jmap(c, o, p))] = r[p];
	return e;
endfunction

function automatic logic [63:0] dgather(input logic [71:0] x);
	logic [63:0] g;
	for (int k = 0; k < 64; k++)
		g[k] = x[(k / 8) * 9 + k % 8];
	return g;
endfunction

function automatic logic [7:0] pgather(input logic [71:0] x);
	logic [7:0] g;
	for (int k = 0; k < 8; k++)
		g[k] = x[k * 9 + 8];
	return g;
endfunction

function automatic logic [71:0] lanes(input logic [63:0] d,
	input logic [7:0] c);
	logic [71:0] l;
	for (int k = 0; k < 64; k++)
		l[(k / 8) * 9 + k % 8] = d[k];
	for (int k = 0; k < 8; k++)
		l[k * 9 + 8] = c[k];
	return l;
endfunction

// ==========================================================================
// hamming secded over 64 bits, check bits at power-of-two positions
function automatic logic [7:0] ecc_enc(input logic [63:0] d);
	logic [71:0] cw;
	logic [7:0] c;
	int i;
	cw = '0;
	c = '0;
	i = 0;
	for (int p = 1; p < 72; p++)
		if ((p & (p - 1)) != 0)
		begin
			cw[p] = d[i];
			i++;
		end
	for (int k = 0; k < 7; k++)
		for (int p = 1; p < 72; p++)
			if (((p >> k) & 1) == 1)
				c[k] = c[k] ^ cw[p];
	c[7] = ^d ^ ^c[6:0];
	return c;
endfunction

// returns {double, single, corrected data}
function automatic logic [65:0] ecc_dec(input logic [63:0] d,
	input logic [7:0] c);
	logic [7:0] e;
	logic [6:0] s;
	logic ovr;
	logic [63:0] o;
	int i;
	e = ecc_enc(d);
	s = e[6:0] ^ c[6:0];
	ovr = ^d ^ ^c;
	o = d;
	i = 0;
	for (int p = 1; p < 72; p++)
		if ((p & (p - 1)) != 0)
		begin
			if (ovr && s == 7'(p))
				o[i] = ~d[i];
			i++;
		end
	return {~ovr && s != 7'h00, ovr, o};
endfunction

// ==========================================================================
// configuration
logic [71:0] mem_r [0:DPBRF_ROWS-1];
logic [DPBRF_CFG_W-1:0] cfg_r;
logic [15:0] af_thr_r;
logic [15:0] ae_thr_r;
logic [15:0] wptr_r;
logic [15:0] rptr_r;
logic fifo_m, split_m, srw_m, srw_e, ecc_m, casc_m, a_oreg, b_oreg;
logic [2:0] mx, a_c, b_c, b_c0, a_cw, b_cw;
dpbrf_wmode_t a_wm, b_wm;

assign fifo_m = cfg_r[DPBRF_CFG_FIFO];
assign split_m = cfg_r[DPBRF_CFG_SPLIT];
assign srw_m = cfg_r[DPBRF_CFG_SRW] & ~fifo_m;
assign srw_e = cfg_r[DPBRF_CFG_SRW] | fifo_m;
assign ecc_m = cfg_r[DPBRF_CFG_ECC];
assign casc_m = cfg_r[DPBRF_CFG_CASC] & fifo_m;
assign a_oreg = cfg_r[DPBRF_CFG_A_OREG];
assign b_oreg = cfg_r[DPBRF_CFG_B_OREG];
assign a_cw = cfg_r[DPBRF_CFG_A_W +: 3];
assign b_cw = cfg_r[DPBRF_CFG_B_W +: 3];
assign a_wm = dpbrf_wmode_t'(cfg_r[DPBRF_CFG_A_WM +: 2]);
assign b_wm = dpbrf_wmode_t'(cfg_r[DPBRF_CFG_B_WM +: 2]);
// widest legal width depends on half/full size and port mode
assign mx = split_m ? (srw_e ? DPBRF_W_X36 : DPBRF_W_X18) :
	(srw_e ? DPBRF_W_X72 : DPBRF_W_X36); // R4 R7
assign a_c = (a_cw > mx) ? mx : a_cw; // R1 R2
assign b_c0 = (b_cw > mx) ? mx : b_cw; // R1 R2
// if neither side is at full width the write side is pinned to it
assign b_c = (srw_m && a_c != mx && b_c0 != mx) ? mx : b_c0; // R6

// ==========================================================================
// fifo control
logic [15:0] cnt, depth, free_u, wunit, runit;
logic push_req, pop_req, push_ok, pop_ok;

assign wunit = 16'h0001 << b_c; // R15
assign runit = 16'h0001 << a_c; // R15
assign depth = split_m ? DPBRF_HALF_UNITS : DPBRF_FULL_UNITS; // R11
assign cnt = wptr_r - rptr_r;
assign free_u = depth - cnt;
assign fifo_full_o = fifo_m & (cnt > depth - wunit); // R13
assign fifo_empty_o = fifo_m & (cnt < runit); // R13
assign fifo_afull_o = fifo_m & (free_u <= af_thr_r); // R13 R14
assign fifo_aempty_o = fifo_m & (cnt <= ae_thr_r); // R13 R14
// one word may still be in flight from the upstream fifo
assign casc_ready_o = fifo_m & (free_u >= 16'(wunit << 1)); // R16
assign push_req = casc_m ? casc_push_i : b_en_i & b_we_i; // R16
assign pop_req = casc_m ? casc_ready_i : a_en_i; // R16
assign push_ok = fifo_m & push_req & ~fifo_full_o; // R21
assign pop_ok = fifo_m & pop_req & ~fifo_empty_o; // R21

always_ff @(posedge clk_i)
begin
	if (!nrst_i || (reg_wr_i && reg_addr_i == DPBRF_REG_FIFO_CLR))
	begin
		wptr_r <= '0;
		rptr_r <= '0;
	end
	else
	begin
		if (push_ok)
			wptr_r <= wptr_r + wunit; // R12
		if (pop_ok)
			rptr_r <= rptr_r + runit; // R12
	end
end

// ==========================================================================
// port access
logic [14:0] a_ua, b_ua, a_u, b_u;
logic a_wr, a_rd, b_wr, b_rd, a_hold, b_hold, a_ecc_on;
logic [71:0] a_old, b_old, a_new, b_new, b_base, b_src, b_wd, b_m;
logic [71:0] a_rx, b_rx, a_rdat;
logic [65:0] a_dec;

assign a_ua = fifo_m ? rptr_r[14:0] : 15'(a_addr_i << a_c);
assign b_ua = fifo_m ? wptr_r[14:0] : 15'(b_addr_i << b_c);
// in split mode the top unit bit picks the half; a fifo uses the low one
assign a_u = {split_m ? a_half_i & ~fifo_m : a_ua[14], a_ua[13:0]}; // R3
assign b_u = {split_m ? b_half_i & ~fifo_m : b_ua[14], b_ua[13:0]}; // R3
assign a_wr = ~srw_e & a_en_i & a_we_i; // R5
assign a_rd = fifo_m ? pop_ok : a_en_i;
assign b_wr = fifo_m ? push_ok : b_en_i & b_we_i;
assign b_rd = ~srw_e & b_en_i; // R5
assign a_hold = a_wr && a_wm == DPBRF_WM_HOLD; // R20
assign b_hold = b_wr && b_wm == DPBRF_WM_HOLD; // R20
assign a_old = mem_r[a_u[14:6]]; // R17
assign b_old = mem_r[b_u[14:6]]; // R17
assign a_new = (a_old & ~lmask(a_c, a_u[5:0])) |
	spread(a_c, a_u[5:0], a_din_i);
assign b_src = casc_m ? casc_din_i : b_din_i; // R16
assign b_wd = (ecc_m && b_c == DPBRF_W_X72) ?
	lanes(dgather(b_src), ecc_enc(dgather(b_src))) : b_src; // R8
// same-row writes merge so neither port loses its bits
assign b_base = (a_wr && a_u[14:6] == b_u[14:6]) ? a_new : b_old;
assign b_m = lmask(b_c, b_u[5:0]);
assign b_new = (b_base & ~b_m) | spread(b_c, b_u[5:0], b_wd);
assign a_rx = extract(a_c, a_u[5:0],
	(a_wr && a_wm == DPBRF_WM_WRFIRST) ? a_new : a_old); // R20
assign b_rx = extract(b_c, b_u[5:0],
	(b_wr && b_wm == DPBRF_WM_WRFIRST) ? b_new : b_old); // R20
assign a_ecc_on = ecc_m && a_c == DPBRF_W_X72;
assign a_dec = ecc_dec(dgather(a_rx), pgather(a_rx)); // R9
assign a_rdat = a_ecc_on ? lanes(a_dec[63:0], pgather(a_rx)) : a_rx; // R9

always_ff @(posedge clk_i)
begin
	if (a_wr)
		mem_r[a_u[14:6]] <= a_new; // R18
	if (b_wr)
		mem_r[b_u[14:6]] <= b_new; // R18
end

// ==========================================================================
// read pipelines
logic [71:0] a_s1_r, a_s2_r, b_s1_r, b_s2_r;
logic a_v1_r, a_v2_r, b_v1_r, b_v2_r;
logic a_sbe1_r, a_sbe2_r, a_dbe1_r, a_dbe2_r;

always_ff @(posedge clk_i)
begin
	if (!nrst_i)
	begin
		a_s1_r <= '0;
		a_v1_r <= 1'b0;
		a_sbe1_r <= 1'b0;
		a_dbe1_r <= 1'b0;
	end
	else
	begin
		a_v1_r <= a_rd & ~a_hold;
		a_sbe1_r <= a_rd & ~a_hold & a_ecc_on & a_dec[64]; // R22
		a_dbe1_r <= a_rd & ~a_hold & a_ecc_on & a_dec[65]; // R22
		if (a_rd && !a_hold)
			a_s1_r <= a_rdat; // R18
	end
end

always_ff @(posedge clk_i)
begin
	if (!nrst_i)
	begin
		b_s1_r <= '0;
		b_v1_r <= 1'b0;
	end
	else
	begin
		b_v1_r <= b_rd & ~b_hold;
		if (b_rd && !b_hold)
			b_s1_r <= b_rx; // R18
	end
end

// the extra stage trades one cycle of latency for clock rate
always_ff @(posedge clk_i)
begin
	if (!nrst_i)
	begin
		a_s2_r <= '0;
		b_s2_r <= '0;
		{a_v2_r, b_v2_r, a_sbe2_r, a_dbe2_r} <= 4'h0;
	end
	else
	begin
		a_s2_r <= a_s1_r; // R19
		b_s2_r <= b_s1_r; // R19
		{a_v2_r, b_v2_r, a_sbe2_r, a_dbe2_r} <=
			{a_v1_r, b_v1_r, a_sbe1_r, a_dbe1_r};
	end
end

assign a_dout_o = a_oreg ? a_s2_r : a_s1_r; // R19
assign a_valid_o = a_oreg ? a_v2_r : a_v1_r;
assign a_sbe_o = a_oreg ? a_sbe2_r : a_sbe1_r; // R22
assign a_dbe_o = a_oreg ? a_dbe2_r : a_dbe1_r; // R22
assign b_dout_o = b_oreg ? b_s2_r : b_s1_r; // R19
assign b_valid_o = b_oreg ? b_v2_r : b_v1_r;
assign casc_valid_o = casc_m & a_valid_o; // R16

// ==========================================================================
// standalone ecc for external memories
logic [65:0] x_dec;
assign x_dec = ecc_dec(ecc_dec_din_i[63:0], ecc_dec_din_i[71:64]);

always_ff @(posedge clk_i)
begin
	if (!nrst_i)
	begin
		ecc_enc_chk_o <= '0;
		{ecc_dec_dbe_o, ecc_dec_sbe_o, ecc_dec_dout_o} <= '0;
	end
	else
	begin
		ecc_enc_chk_o <= ecc_enc(ecc_enc_din_i); // R10
		{ecc_dec_dbe_o, ecc_dec_sbe_o, ecc_dec_dout_o} <= x_dec; // R10
	end
end

// ==========================================================================
// register port
always_ff @(posedge clk_i)
begin
	if (!nrst_i)
	begin
		cfg_r <= DPBRF_CFG_RST;
		af_thr_r <= DPBRF_THR_RST;
		ae_thr_r <= DPBRF_THR_RST;
	end
	else if (reg_wr_i)
	begin
		if (reg_addr_i == DPBRF_REG_CFG)
			cfg_r <= reg_wdata_i[DPBRF_CFG_W-1:0];
		if (reg_addr_i == DPBRF_REG_AF_THR)
			af_thr_r <= reg_wdata_i[15:0]; // R14
		if (reg_addr_i == DPBRF_REG_AE_THR)
			ae_thr_r <= reg_wdata_i[15:0]; // R14
	end
end

always_ff @(posedge clk_i)
begin
	if (!nrst_i || !reg_rd_i)
		reg_rdata_o <= '0;
	else
		unique case (reg_addr_i)
			DPBRF_REG_CFG: reg_rdata_o <= 32'(cfg_r);
			DPBRF_REG_AF_THR: reg_rdata_o <= {16'h0000, af_thr_r};
			DPBRF_REG_AE_THR: reg_rdata_o <= {16'h0000, ae_thr_r};
			DPBRF_REG_STATUS: reg_rdata_o <= {cnt, 12'h000, fifo_aempty_o,
				fifo_afull_o, fifo_empty_o, fifo_full_o};
			default: reg_rdata_o <= '0;
		endcase
end

// ==========================================================================
// assertions
default clocking dpbrf_cb @(posedge clk_i);
endclocking
default disable iff (!nrst_i);

sequence s_a_read;
	a_rd && !a_hold;
endsequence
property p_full_push;
	fifo_full_o && push_req && !reg_wr_i |=> $stable(wptr_r);
endproperty
a_full_push: assert property (p_full_push) else $error("push when full"); // R21
property p_empty_pop;
	fifo_empty_o && !reg_wr_i |=> $stable(rptr_r);
endproperty
a_empty_pop: assert property (p_empty_pop) else $error("pop when empty"); // R21
property p_ptr_step;
	push_ok && !reg_wr_i |=> wptr_r == $past(wptr_r) + $past(wunit);
endproperty
a_ptr_step: assert property (p_ptr_step) else $error("bad push step"); // R12
property p_lat_direct;
	s_a_read ##0 !a_oreg ##1 !a_oreg |-> a_valid_o;
endproperty
a_lat_direct: assert property (p_lat_direct) else $error("lat 1"); // R19
property p_lat_oreg;
	s_a_read ##0 a_oreg ##1 a_oreg[*2] |-> a_valid_o;
endproperty
a_lat_oreg: assert property (p_lat_oreg) else $error("lat 2"); // R19
property p_err_excl;
	a_sbe_o || a_dbe_o |-> a_valid_o && !(a_sbe_o && a_dbe_o);
endproperty
a_err_excl: assert property (p_err_excl) else $error("ecc flags"); // R22
property p_ext_clean;
	ecc_dec_din_i[71:64] == ecc_enc(ecc_dec_din_i[63:0]) |=>
		!ecc_dec_sbe_o && !ecc_dec_dbe_o &&
		ecc_dec_dout_o == $past(ecc_dec_din_i[63:0]);
endproperty
a_ext_clean: assert property (p_ext_clean) else $error("ecc round"); // R10
property p_wide_srw;
	srw_m |-> !a_wr && (a_c == mx || b_c == mx);
endproperty
a_wide_srw: assert property (p_wide_srw) else $error("srw rules"); // R5 R6
property p_half_w;
	split_m && !srw_e |-> a_c <= DPBRF_W_X18 && b_c <= DPBRF_W_X18;
endproperty
a_half_w: assert property (p_half_w) else $error("half width"); // R4
property p_hold;
	a_wr && a_wm == DPBRF_WM_HOLD |=> $stable(a_s1_r) && !a_v1_r;
endproperty
a_hold_dout: assert property (p_hold) else $error("no hold"); // R20
property p_aempty;
	fifo_empty_o && ae_thr_r >= runit |-> fifo_aempty_o;
endproperty
a_aempty: assert property (p_aempty) else $error("aempty"); // R14
endmodule

// file: dpbrf_top_tb_top.sv
// self-checking bench for the dual-port block memory with fifo
`timescale 1ns/100ps
module dpbrf_top_tb_top
	import dpbrf_pkg::*;
;
	logic clk;
	logic rst_n;
	logic [4:0] ra;
	logic [31:0] rwd;
	logic rwr;
	logic rrd;
	logic [31:0] rrdat;
	logic a_en;
	logic a_we;
	logic [14:0] a_addr;
	logic [71:0] a_din;
	logic [71:0] a_dout;
	logic a_valid;
	logic ha;
	logic hb;
	logic asbe;
	logic adbe;
	logic b_en;
	logic b_we;
	logic [14:0] b_addr;
	logic [71:0] b_din;
	logic [71:0] bq;
	logic bv;
	logic crdy;
	logic cv;
	wire [3:0] fl;
	logic [63:0] edin;
	logic [7:0] echk;
	logic [71:0] ddin;
	logic [63:0] edout;
	logic esbe;
	logic edbe;
	int num_errors;
	int compares;
	int unsigned seed;
	int i;
	int c;
	int k;
	int m;
	int w;
	int n;
	int b1;
	int b2;
	logic v;
	logic [71:0] d;
	logic [71:0] q;
	logic [71:0] old;
	logic [71:0] p;
	logic [71:0] dm;
	logic [63:0] x;
	logic [7:0] c8;
	logic [71:0] fq[$];

	dpbrf_top DUT (
		.clk_i(clk), .nrst_i(rst_n), .reg_addr_i(ra), .reg_wdata_i(rwd),
		.reg_wr_i(rwr), .reg_rd_i(rrd), .reg_rdata_o(rrdat),
		.a_en_i(a_en), .a_we_i(a_we), .a_addr_i(a_addr), .a_half_i(ha),
		.a_din_i(a_din), .a_dout_o(a_dout), .a_valid_o(a_valid),
		.a_sbe_o(asbe), .a_dbe_o(adbe), .b_en_i(b_en), .b_we_i(b_we),
		.b_addr_i(b_addr), .b_half_i(hb), .b_din_i(b_din),
		.b_dout_o(bq), .b_valid_o(bv), .fifo_full_o(fl[0]),
		.fifo_empty_o(fl[1]), .fifo_afull_o(fl[2]), .fifo_aempty_o(fl[3]),
		.casc_din_i(72'h0), .casc_push_i(1'b0), .casc_ready_o(crdy),
		.casc_ready_i(1'b0), .casc_valid_o(cv), .ecc_enc_din_i(edin),
		.ecc_enc_chk_o(echk), .ecc_dec_din_i(ddin), .ecc_dec_dout_o(edout),
		.ecc_dec_sbe_o(esbe), .ecc_dec_dbe_o(edbe)
	);

	dpbrf_fab fab (
		.clk_i(clk), .b_en_o(b_en), .b_we_o(b_we), .b_addr_o(b_addr),
		.b_din_o(b_din)
	);

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ========
	// expectations
	// narrow entry k of a 36-bit word: 9-bit lanes, data bits only below x9
	function automatic logic [71:0] nar(logic [71:0] dd, int cc, int kk);
		int u;
		int nb;
		u = kk << cc;
		nb = 1 << cc;
		if (cc >= 3)
		begin
			nb = 9 << (cc - 3);
			return (dd >> (nb * kk)) & ((72'h1 << nb) - 72'h1);
		end
		return (dd >> ((u >> 3) * 9 + (u & 7))) & ((72'h1 << nb) - 72'h1);
	endfunction

	// {aempty, afull, empty, full} for x36 words and thresholds of 64 units
	function automatic logic [3:0] flg(int cnt);
		return {cnt <= 64, 32768 - cnt <= 64, cnt < 32, cnt > 32768 - 32};
	endfunction

	// 64 data bits into the low eight bits of each 9-bit lane
	function automatic logic [71:0] lay(logic [63:0] xx);
		logic [71:0] l;
		l = '0;
		for (int j = 0; j < 64; j++)
			l[(j / 8) * 9 + j % 8] = xx[j];
		return l;
	endfunction

	// ========
	// bus tasks
	task automatic chk(string nm, logic [71:0] e, logic [71:0] g);
		compares++;
		if (g !== e)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic rwrite(logic [4:0] a, logic [31:0] dd);
		@(posedge clk);
		ra <= a;
		rwd <= dd;
		rwr <= 1'b1;
		@(posedge clk);
		rwr <= 1'b0;
	endtask

	task automatic rread(logic [4:0] a, logic [31:0] e);
		@(posedge clk);
		ra <= a;
		rrd <= 1'b1;
		@(posedge clk);
		rrd <= 1'b0;
		#1;
		chk("reg_rdata_o", {40'h0, e}, {40'h0, rrdat});
	endtask

	task automatic acc(logic wen, logic [14:0] a, logic [71:0] dd, int lat,
		output logic vv, output logic [71:0] qq);
		@(posedge clk);
		a_en <= 1'b1;
		a_we <= wen;
		a_addr <= a;
		a_din <= dd;
		@(posedge clk);
		a_en <= 1'b0;
		a_we <= 1'b0;
		a_din <= ~dd;
		repeat (lat - 1) @(posedge clk);
		#1;
		vv = a_valid;
		qq = a_dout;
	endtask

	task automatic dec(logic [71:0] y, logic [63:0] e, logic [1:0] f);
		@(posedge clk);
		ddin <= y;
		@(posedge clk);
		#1;
		chk("ecc_dec_flags", 72'(f), 72'({edbe, esbe}));
		if (f != 2'b10)
			chk("ecc_dec_dout_o", 72'(e), 72'(edout));
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ========
	// watchdog
	initial
	begin
		repeat (30000) @(posedge clk);
		num_errors++;
		finish_test();
	end

	// ========
	// tests
	initial
	begin
		seed = $urandom(32'hE1B8D827);
		rst_n = 1'b0;
		{rwr, rrd, a_en, a_we, ha, hb} = 6'h00;
		ra = 5'h0;
		rwd = 32'h0;
		a_addr = 15'h0;
		a_din = 72'h0;
		edin = 64'h0;
		ddin = 72'h0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rread(DPBRF_REG_CFG, 32'h2D0);
		rread(DPBRF_REG_AF_THR, 32'h40);
		rread(DPBRF_REG_AE_THR, 32'h40);
		rread(DPBRF_REG_STATUS, 32'h0);
		rread(5'h14, 32'h0);
		$display("test registers done");
		// x36 word written on b, read back on a at every width from x1 up to x36
		w = $urandom_range(1023);
		d = 72'({$urandom(), $urandom()}) & 72'hF_FFFF_FFFF;
		fab.wr(15'(w), d, 0);
		#1;
		chk("b_valid_o", 72'h1, 72'(bv));
		chk("b_dout_o", d, bq);
		for (c = 0; c < 6; c++)
		begin
			rwrite(DPBRF_REG_CFG, 32'h280 | 32'(c << 4));
			k = $urandom_range((32 >> c) - 1);
			acc(1'b0, 15'((w << (5 - c)) + k), 72'h0, 1, v, q);
			chk("a_valid_o", 72'h1, 72'(v));
			chk("a_dout_o", nar(d, c, k), q);
		end
		rwrite(DPBRF_REG_CFG, 32'h6D0);
		acc(1'b0, 15'(w), 72'h0, 2, v, q);
		chk("a_valid_o", 72'h1, 72'(v));
		chk("a_dout_o", d, q);
		$display("test aspect and latency done");
		for (m = 0; m < 3; m++)
		begin
			rwrite(DPBRF_REG_CFG, 32'h2D0 | 32'(m << 12));
			old = 72'({$urandom(), $urandom()}) & 72'hF_FFFF_FFFF;
			acc(1'b1, 15'(w), old, 1, v, q);
			p = a_dout;
			d = 72'({$urandom(), $urandom()}) & 72'hF_FFFF_FFFF;
			acc(1'b1, 15'(w), d, 1, v, q);
			chk("a_valid_o", 72'(m != 2), 72'(v));
			chk("a_dout_o", (m == 0) ? d : ((m == 1) ? old : p), q);
		end
		$display("test write modes done");
		// same entry in both halves must hold two different words
		rwrite(DPBRF_REG_CFG, 32'h242);
		w = $urandom_range(1023);
		old = 72'($urandom()) & 72'h3_FFFF;
		d = 72'($urandom()) & 72'h3_FFFF;
		hb <= 1'b0;
		fab.wr(15'(w), old, 0);
		hb <= 1'b1;
		fab.wr(15'(w), d, 0);
		ha <= 1'b0;
		acc(1'b0, 15'(w), 72'h0, 1, v, q);
		chk("a_dout_o", old, q);
		ha <= 1'b1;
		acc(1'b0, 15'(w), 72'h0, 1, v, q);
		chk("a_dout_o", d, q);
		$display("test split halves done");
		rwrite(DPBRF_REG_CFG, 32'h2D1);
		rwrite(DPBRF_REG_FIFO_CLR, 32'h0);
		n = 0;
		#1;
		chk("fifo flags", 72'(flg(0)), 72'(fl));
		// one push beyond full must be dropped
		for (i = 0; i < 1025; i++)
		begin
			d = 72'({$urandom(), $urandom()}) & 72'hF_FFFF_FFFF;
			fab.wr(15'h0, d, $urandom_range(2));
			if (n < 32768)
			begin
				fq.push_back(d);
				n += 32;
			end
			#1;
			chk("fifo flags", 72'(flg(n)), 72'(fl));
			chk("casc_ready_o", 72'(32768 - n >= 64), 72'(crdy));
		end
		rread(DPBRF_REG_STATUS, {n[15:0], 12'h0, flg(n)});
		for (i = 0; i < 1025; i++)
		begin
			acc(1'b0, 15'h0, 72'h0, 1, v, q);
			chk("a_valid_o", 72'(fq.size() != 0), 72'(v));
			if (fq.size() != 0)
			begin
				chk("a_dout_o", fq.pop_front(), q);
				n -= 32;
			end
			chk("fifo flags", 72'(flg(n)), 72'(fl));
			chk("casc_valid_o", 72'h0, 72'(cv));
		end
		$display("test fifo done");
		for (i = 0; i < 8; i++)
		begin
			x = {$urandom(), $urandom()};
			@(posedge clk);
			edin <= x;
			@(posedge clk);
			#1;
			c8 = echk;
			b1 = $urandom_range(71);
			b2 = (b1 + 1 + $urandom_range(70)) % 72;
			dec({c8, x}, x, 2'b00);
			dec({c8, x} ^ (72'h1 << b1), x, 2'b01);
			dec({c8, x} ^ (72'h1 << b1) ^ (72'h1 << b2), x, 2'b10);
		end
		$display("test ecc done");
		// stored words: errors injected by raw writes with ecc off
		dm = lay(64'hFFFF_FFFF_FFFF_FFFF);
		for (i = 0; i < 4; i++)
		begin
			x = {$urandom(), $urandom()};
			w = $urandom_range(511);
			b1 = $urandom_range(63);
			b2 = (b1 + 1 + $urandom_range(62)) % 64;
			rwrite(DPBRF_REG_CFG, 32'h36C);
			fab.wr(15'(w), lay(x), 0);
			acc(1'b0, 15'(w), 72'h0, 1, v, q);
			chk("a_dout_o", lay(x), q & dm);
			chk("a_ecc_flags", 72'h0, 72'({adbe, asbe}));
			rwrite(DPBRF_REG_CFG, 32'h364);
			acc(1'b1, 15'(w), 72'h0, 1, v, q);
			p = q;
			acc(1'b0, 15'(w), 72'h0, 1, v, q);
			chk("a_dout_o", p, q);
			chk("a_dout_o", lay(x), p & dm);
			for (k = 1; k < 3; k++)
			begin
				rwrite(DPBRF_REG_CFG, 32'h364);
				d = p ^ lay(64'h1 << b1) ^ lay(64'(k - 1) << b2);
				fab.wr(15'(w), d, 0);
				rwrite(DPBRF_REG_CFG, 32'h36C);
				acc(1'b0, 15'(w), 72'h0, 1, v, q);
				chk("a_ecc_flags", 72'(k), 72'({adbe, asbe}));
				if (k == 1)
					chk("a_dout_o", p, q);
			end
		end
		$display("test stored ecc done");
		finish_test();
	end
endmodule
